// ==== logic/timer8_channel.sv ====
// one 8-bit timer channel: clock select, compare, flags, output
// assumes an apb master on core_clk and asynchronous pins
`timescale 1ns/1ps
module timer8_channel #(
  parameter int CHANNEL = 0 // 0 or 1, picks prescale table
) (
  input wire logic core_clk,        // system clock, 25 MHz
  input wire logic sys_rst,         // async reset, active high
  input wire logic clkEn,           // freezes all state when low
  input wire logic standby,         // standby entry, reinitialises
  input wire logic [7:0] paddr,     // apb byte address
  input wire logic psel,            // apb select
  input wire logic penable,         // apb access phase
  input wire logic pwrite,          // apb direction
  input wire logic [31:0] pwdata,   // apb write data
  input wire logic [3:0] pstrb,     // apb byte strobes
  output logic [31:0] prdata,       // apb read data
  output logic pready,              // apb ready
  output logic pslverr,             // apb error, unmapped address
  input wire logic externalCountInput, // external clock pin
  input wire logic externalClearInput, // external counter clear pin
  output logic timerOutputPin,      // timer output level
  output logic timerOutputActive    // output enabled
);
  timer8_pkg::state_t s;      // current state
  timer8_pkg::state_t next_s; // next state

  // bus decode
  logic setup;
  logic access;
  logic wrEn;
  logic mapped;
  // write hits per register
  logic wrCtl;
  logic wrSts;
  logic wrA;
  logic wrB;
  logic wrCnt;
  logic wrVar;
  // counting
  logic [2:0] cks;
  logic [1:0] clrSel;
  logic variantBit;
  logic selLevel;
  logic tick;
  logic extRise;
  logic extFall;
  logic clrRise;
  logic matchA;
  logic matchB;
  logic [7:0] countAhead; // counter value after this cycle's tick
  logic pwmB;             // pwm duty edge: entering constant b
  logic satur;
  logic clearCnt;
  logic [1:0] actA;
  logic [1:0] actB;
  logic [1:0] act;

  // apply one action to a level
  function automatic logic applyAct(input logic [1:0] a,
                                    input logic lvl);
    logic r;
    r = lvl;
    case (a)
      timer8_pkg::ACT_LOW: r = 1'b0;
      timer8_pkg::ACT_HIGH: r = 1'b1;
      timer8_pkg::ACT_TOGGLE: r = ~lvl;
      default: r = lvl;
    endcase
    return r;
  endfunction

  // apb phases; zero wait states, stalled while frozen
  always_comb begin
    setup = psel & ~penable;
    access = psel & penable & clkEn;
    wrEn = access & pwrite & pstrb[0];
    mapped = (paddr == timer8_pkg::OFS_CONTROL) ||
             (paddr == timer8_pkg::OFS_STATUS) ||
             (paddr == timer8_pkg::OFS_CONST_A) ||
             (paddr == timer8_pkg::OFS_CONST_B) ||
             (paddr == timer8_pkg::OFS_COUNT) ||
             (paddr == timer8_pkg::OFS_VARIANT);
    wrCtl = wrEn & (paddr == timer8_pkg::OFS_CONTROL);
    wrSts = wrEn & (paddr == timer8_pkg::OFS_STATUS);
    wrA = wrEn & (paddr == timer8_pkg::OFS_CONST_A);
    wrB = wrEn & (paddr == timer8_pkg::OFS_CONST_B);
    wrCnt = wrEn & (paddr == timer8_pkg::OFS_COUNT);
    wrVar = wrEn & (paddr == timer8_pkg::OFS_VARIANT);
  end

  // handshake outputs are combinational, data is registered
  always_comb begin
    pready = clkEn;
    pslverr = psel & penable & ~mapped;
    prdata = s.rdata;
    timerOutputPin = s.outLevel;
    timerOutputActive = (s.outSel != 4'h0);
  end

  // select the prescaler tap from clock select and variant
  always_comb begin
    cks = s.control[timer8_pkg::POS_CKS_LO +: 3];
    clrSel = s.control[timer8_pkg::POS_CLR_LO +: 2];
    variantBit = (CHANNEL == 0) ? s.variant[0] : s.variant[1];
    selLevel = 1'b0; // stopped and external codes feed no tap
    case (cks)
      3'h1: selLevel = variantBit ? s.prescale[0] // /2
                                  : s.prescale[2]; // /8
      3'h2: begin
        if (!variantBit) begin
          selLevel = s.prescale[5]; // /64
        end else if (CHANNEL == 0) begin
          selLevel = s.prescale[4]; // /32
        end else begin
          selLevel = s.prescale[6]; // /128
        end
      end
      3'h3: begin
        if (!variantBit) begin
          selLevel = s.prescale[9]; // /1024
        end else if (CHANNEL == 0) begin
          selLevel = s.prescale[7]; // /256
        end else begin
          selLevel = s.prescale[10]; // /2048
        end
      end
      default: selLevel = 1'b0;
    endcase
  end

  // edges from the filtered pin levels; second and third must agree
  always_comb begin
    extRise = (s.cntSync[1] == s.cntSync[2]) & s.cntSync[1] &
              ~s.cntLevel;
    extFall = (s.cntSync[1] == s.cntSync[2]) & ~s.cntSync[1] &
              s.cntLevel;
    clrRise = (s.clrSync[1] == s.clrSync[2]) & s.clrSync[1] &
              ~s.clrLevel;
    // one count pulse per core clock at most
    case (cks)
      3'h1, 3'h2, 3'h3: tick = s.preLevel & ~selLevel;
      3'h5: tick = extRise;
      3'h6: tick = extFall;
      3'h7: tick = extRise | extFall;
      default: tick = 1'b0; // codes 000 and 100
    endcase
  end

  // compare matches in the last state before the counter moves
  always_comb begin
    // pwm with a below b: b never matches, output saturates
    satur = s.pwmEnable & (s.constantA < s.compareB);
    // a write to a constant in this cycle masks its match
    matchA = tick & (s.countValue == s.constantA) & ~wrA;
    matchB = tick & (s.countValue == s.compareB) & ~wrB &
             ~satur;
    case (clrSel)
      timer8_pkg::CLR_MATCH_A: clearCnt = matchA;
      timer8_pkg::CLR_MATCH_B: clearCnt = matchB;
      timer8_pkg::CLR_PIN: clearCnt = clrRise;
      default: clearCnt = 1'b0; // never
    endcase
    // pwm ends the pulse on entering b, so the width is b periods
    countAhead = clearCnt ? timer8_pkg::RST_COUNT
                          : s.countValue + 8'h01;
    pwmB = tick & s.pwmEnable & ~satur & ~wrB &
           (countAhead == s.compareB);
  end

  // resolve the output action for this cycle
  always_comb begin
    actA = matchA ? s.outSel[1:0] : timer8_pkg::ACT_NONE;
    actB = (s.pwmEnable ? pwmB : matchB) ? s.outSel[3:2]
                                         : timer8_pkg::ACT_NONE;
    if (s.pwmEnable) begin
      // pwm: the b change wins when both fire
      act = (actB != timer8_pkg::ACT_NONE) ? actB : actA;
    end else if ((actA == timer8_pkg::ACT_TOGGLE) ||
                 (actB == timer8_pkg::ACT_TOGGLE)) begin
      act = timer8_pkg::ACT_TOGGLE;
    end else if ((actA == timer8_pkg::ACT_HIGH) ||
                 (actB == timer8_pkg::ACT_HIGH)) begin
      act = timer8_pkg::ACT_HIGH;
    end else if ((actA == timer8_pkg::ACT_LOW) ||
                 (actB == timer8_pkg::ACT_LOW)) begin
      act = timer8_pkg::ACT_LOW;
    end else begin
      act = timer8_pkg::ACT_NONE;
    end
  end

  // next state of the whole channel
  always_comb begin
    next_s = s;
    if (clkEn) begin
      // free running divider and selected tap history
      next_s.prescale = s.prescale + 1'b1;
      next_s.preLevel = selLevel; // a source change may count once
      // pin synchronisers; first stage only feeds the second
      next_s.cntSync = {s.cntSync[1:0], externalCountInput};
      next_s.clrSync = {s.clrSync[1:0], externalClearInput};
      if (s.cntSync[1] == s.cntSync[2]) begin
        next_s.cntLevel = s.cntSync[1];
      end
      if (s.clrSync[1] == s.clrSync[2]) begin
        next_s.clrLevel = s.clrSync[1];
      end

      // read data captured in the setup cycle
      if (setup & ~pwrite) begin
        case (paddr)
          timer8_pkg::OFS_CONTROL: next_s.rdata = {24'h0, s.control};
          timer8_pkg::OFS_STATUS:
            next_s.rdata = {24'h0, s.flags, s.pwmEnable, s.outSel};
          timer8_pkg::OFS_CONST_A: next_s.rdata = {24'h0, s.constantA};
          timer8_pkg::OFS_CONST_B: next_s.rdata = {24'h0, s.bufferB};
          timer8_pkg::OFS_COUNT: next_s.rdata = {24'h0, s.countValue};
          timer8_pkg::OFS_VARIANT: next_s.rdata = {30'h0, s.variant};
          default: next_s.rdata = 32'h0;
        endcase
      end

      // a completed status read arms the flags it saw as one
      if (access & ~pwrite & (paddr == timer8_pkg::OFS_STATUS)) begin
        next_s.armed = s.rdata[timer8_pkg::POS_OVF +: 3];
      end

      // software writes to plain fields
      if (wrCtl) begin
        next_s.control = pwdata[7:0];
      end
      if (wrVar) begin
        next_s.variant = pwdata[1:0];
      end
      if (wrA) begin
        next_s.constantA = pwdata[7:0];
      end
      if (wrB) begin
        next_s.bufferB = pwdata[7:0];
        if (!s.pwmEnable) begin
          next_s.compareB = pwdata[7:0]; // normal mode: direct
        end
      end
      if (wrSts) begin
        next_s.pwmEnable = pwdata[timer8_pkg::POS_PWM];
        next_s.outSel = pwdata[3:0];
        // writing one never sets; zero clears only armed flags
        next_s.flags = s.flags &
          ~(s.armed & ~pwdata[timer8_pkg::POS_OVF +: 3]);
        next_s.armed = 3'h0;
      end

      // pwm: buffered b moves across on match a
      if (s.pwmEnable & matchA) begin
        next_s.compareB = wrB ? pwdata[7:0] : s.bufferB;
      end

      // counter: clear beats write, write beats increment
      if (clearCnt) begin
        next_s.countValue = timer8_pkg::RST_COUNT;
      end else if (wrCnt) begin
        next_s.countValue = pwdata[7:0];
      end else if (tick) begin
        next_s.countValue = s.countValue + 1'b1;
      end

      // flags set in the event cycle; set wins over clear
      if (matchB) begin
        next_s.flags[2] = 1'b1;
      end
      if (matchA) begin
        next_s.flags[1] = 1'b1;
      end
      if (tick & ~clearCnt & ~wrCnt & (s.countValue == 8'hFF)) begin
        next_s.flags[0] = 1'b1;
      end

      // output follows the resolved action
      next_s.outLevel = applyAct(act, s.outLevel);

      // standby reinitialises the channel registers, all but variant
      if (standby) begin
        next_s.control = timer8_pkg::RST_CONTROL;
        next_s.flags = 3'h0;
        next_s.armed = 3'h0;
        next_s.pwmEnable = 1'b0;
        next_s.outSel = 4'h0;
        next_s.constantA = timer8_pkg::RST_CONST;
        next_s.compareB = timer8_pkg::RST_CONST;
        next_s.bufferB = timer8_pkg::RST_CONST;
        next_s.countValue = timer8_pkg::RST_COUNT;
        next_s.outLevel = 1'b0;
      end
    end
  end

  // state register; constants only under reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s.control <= timer8_pkg::RST_CONTROL;
      s.flags <= 3'h0;
      s.armed <= 3'h0;
      s.pwmEnable <= 1'b0;
      s.outSel <= 4'h0;
      s.constantA <= timer8_pkg::RST_CONST;
      s.compareB <= timer8_pkg::RST_CONST;
      s.bufferB <= timer8_pkg::RST_CONST;
      s.countValue <= timer8_pkg::RST_COUNT;
      s.variant <= timer8_pkg::RST_VARIANT;
      s.prescale <= '0;
      s.preLevel <= 1'b0;
      s.cntSync <= 3'h0;
      s.cntLevel <= 1'b0;
      s.clrSync <= 3'h0;
      s.clrLevel <= 1'b0;
      s.outLevel <= 1'b0; // low until a match moves it
      s.rdata <= 32'h0;
    end else begin
      s <= next_s;
    end
  end
endmodule // timer8_channel

// ==== logic/timer8_pkg.sv ====
// package: register map, field positions, reset values, state record
// assumes a 32-bit apb slave with one register per aligned word
package timer8_pkg;
  // byte offsets of the register words
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONST_A = 8'h08;
  localparam logic [7:0] OFS_CONST_B = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_VARIANT = 8'h14;
  // status/output control field positions
  localparam int POS_FLAG_B = 7;
  localparam int POS_FLAG_A = 6;
  localparam int POS_OVF = 5;
  localparam int POS_PWM = 4;
  // control register field positions
  localparam int POS_CLR_LO = 3;
  localparam int POS_CKS_LO = 0;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CONST = 8'hFF;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [1:0] RST_VARIANT = 2'h0;
  // prescaler width covers the largest divide, 2048
  localparam int PRE_W = 11;
  // output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // clear selections
  localparam logic [1:0] CLR_NEVER = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam logic [1:0] CLR_PIN = 2'h3;

  // whole channel state, registered as one record
  typedef struct packed {
    logic [7:0] control;     // clear select, clock select
    logic [2:0] flags;       // b, a, overflow
    logic [2:0] armed;       // flags seen as one by a read
    logic pwmEnable;         // pwm mode
    logic [3:0] outSel;      // b action hi, a action lo
    logic [7:0] constantA;   // compare a
    logic [7:0] compareB;    // active compare b
    logic [7:0] bufferB;     // software copy of constant b
    logic [7:0] countValue;  // counter
    logic [1:0] variant;     // prescale variant bits ch1, ch0
    logic [PRE_W-1:0] prescale; // free running divider
    logic preLevel;          // last selected divider level
    logic [2:0] cntSync;     // count pin synchroniser
    logic cntLevel;          // filtered count pin level
    logic [2:0] clrSync;     // clear pin synchroniser
    logic clrLevel;          // filtered clear pin level
    logic outLevel;          // timer output level
    logic [31:0] rdata;      // read data
  } state_t;
endpackage

// ==== tb/timer8_channel_props.sv ====
// checker: port-level timing of one timer channel
// assumes it is bound onto timer8_channel and sees only its ports
`timescale 1ns/1ps
module timer8_channel_props (
  input wire logic core_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic clkEn, // run enable
  input wire logic standby, // standby level
  input wire logic [7:0] paddr, // address
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [31:0] pwdata, // write data
  input wire logic [3:0] pstrb, // strobes
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic timerOutputPin, // output level
  input wire logic timerOutputActive // output enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic wrEv; // completed write
  logic [2:0] clkSel; // mirrored clock select
  logic stopped; // no clock source selected
  assign wrEv = psel && penable && pwrite && pstrb[0] && clkEn;
  assign stopped = (clkSel == 3'h0 || clkSel == 3'h4) && !standby;
  // mirror of clock select, so the stopped case is known here
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) clkSel <= 3'h0;
    else if (standby && clkEn) clkSel <= 3'h0;
    else if (wrEv && paddr == 8'h00) clkSel <= pwdata[2:0];
  end
  ready_follows_a: assert property (
    pready == clkEn) else $error("ready not equal to enable");
  unmapped_err_a: assert property (
    psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
    else $error("error flag wrong for address");
  idle_noerr_a: assert property (
    !(psel && penable) |-> !pslverr) else $error("error outside access");
  upper_zero_a: assert property (
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  standby_init_a: assert property (
    standby && clkEn |=> !timerOutputPin && !timerOutputActive)
    else $error("standby left output alive");
  reset_low_a: assert property (
    $fell(sys_rst) |-> !timerOutputPin && !timerOutputActive)
    else $error("output not low after reset");
  out_enable_a: assert property (
    wrEv && paddr == 8'h04 && !standby
    |=> timerOutputActive == (|$past(pwdata[3:0])))
    else $error("output enable not from select bits");
  stopped_hold_a: assert property (
    stopped [*4] |=> $stable(timerOutputPin))
    else $error("output moved with timer stopped");
  cover property (timerOutputPin ##1 !timerOutputPin);
  cover property (pslverr);
  cover property (standby && clkEn);
endmodule // timer8_channel_props

// ==== tb/timer8_pin_model.sv ====
// partner: external count and clear sources plus the output load
// assumes pulses far wider than the minimum of 2.5 clock periods
`timescale 1ns/1ps
module timer8_pin_model (
  input wire logic outLevel, // timer output load
  output logic countPin, // external count source
  output logic clearPin // external clear source
);
  int loadRises; // rising edges seen by the load
  // lines rest low between bursts, like an idle source
  initial begin
    countPin = 1'b0;
    clearPin = 1'b0;
    loadRises = 0;
  end
  always @(posedge outLevel) loadRises++;
  // 200 ns per level: five clock periods each way
  // the first 10 ns keep every pin change off the clock edge
  task automatic sendPulses(input int n);
    #10;
    repeat (n) begin
      #200 countPin = 1'b1;
      #200 countPin = 1'b0;
    end
  endtask
  task automatic pulseClear();
    #210 clearPin = 1'b1;
    #200 clearPin = 1'b0;
  endtask
endmodule // timer8_pin_model

// ==== tb/test_timer8_clock_flags_output.sv ====
// testbench: channel 0 driven over apb, pins from the partner model
// assumes 25 MHz clock and the design's register map
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin \
  fails++; $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_timer8_clock_flags_output;
  logic core_clk = 1'b0; // clock
  logic sys_rst = 1'b1; // reset
  logic clkEn = 1'b1; // run enable
  logic standby = 1'b0; // standby
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb control
  logic [7:0] paddr = 8'h00; // address
  logic [31:0] pwdata = 32'h0, prdata; // data
  logic [3:0] pstrb = 4'hF; // strobes
  logic pready, pslverr, cntPin, clrPin, outPin, outAct; // wires
  logic lastErr; // error seen at last access
  logic [7:0] rd, first; // read results
  logic [7:0] rstTab [5] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  int divTab [6] = '{8, 2, 64, 32, 1024, 256}; // ch0 prescales
  int fails = 0, totalChecks = 0, cycles = 0, n; // counters
  timer8_channel #(.CHANNEL(0)) timer8_channel_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .standby(standby), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .externalCountInput(cntPin),
    .externalClearInput(clrPin), .timerOutputPin(outPin),
    .timerOutputActive(outAct));
  timer8_pin_model timer8_pin_model_i (
    .outLevel(outPin), .countPin(cntPin), .clearPin(clrPin));
  always #20 core_clk = ~core_clk;
  // hang guard: the sequence needs well under 20000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      endOfTest();
    end
  end
  // one apb transfer; released only after ready is seen
  task automatic apb(input logic [7:0] a, input logic wr,
      input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata[7:0];
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdChk(input string nm, input logic [7:0] a,
      input logic [7:0] ex);
    apb(a, 1'b0, 8'h00);
    `CHK(nm, ex, rd)
  endtask
  // length of the next whole run of the output at level lvl
  task automatic runLen(input logic lvl);
    n = 0;
    while (outPin === lvl) @(posedge core_clk);
    while (outPin !== lvl) @(posedge core_clk);
    while (outPin === lvl) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) rdChk("reset", 8'(4 * i), rstTab[i]);
    apb(8'h18, 1'b0, 8'h00);
    `CHK("unmapped", 1'b1, lastErr)
    for (int i = 0; i < 2; i++) begin
      wr(8'h00, i ? 8'h04 : 8'h00);
      wr(8'h10, 8'h5A);
      repeat (30) @(posedge core_clk);
      rdChk("stopped count", 8'h10, 8'h5A);
    end
    // reads spaced by four prescaled periods see exactly four ticks
    for (int i = 0; i < 6; i++) begin
      wr(8'h14, {7'h0, i[0]});
      wr(8'h00, 8'(i / 2 + 1));
      apb(8'h10, 1'b0, 8'h00);
      first = rd;
      repeat (4 * divTab[i] - 2) @(posedge core_clk);
      rdChk("prescaled", 8'h10, first + 8'h04);
    end
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h03);
    wr(8'h04, 8'h03);
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h09);
    runLen(1'b1);
    `CHK("toggle half", 8, n)
    wr(8'h00, 8'h08);
    rdChk("match a flag", 8'h04, 8'h43);
    wr(8'h04, 8'hE3);
    wr(8'h04, 8'h03);
    rdChk("flag kept", 8'h04, 8'h43);
    wr(8'h04, 8'h03);
    rdChk("flag cleared", 8'h04, 8'h03);
    wr(8'h04, 8'h00);
    wr(8'h10, 8'hFC);
    wr(8'h00, 8'h01);
    repeat (40) @(posedge core_clk);
    wr(8'h00, 8'h00);
    rdChk("wrap flags", 8'h04, 8'hE0);
    `CHK("output off", 1'b0, outAct)
    wr(8'h00, 8'h18);
    wr(8'h10, 8'h40);
    timer8_pin_model_i.pulseClear();
    repeat (4) @(posedge core_clk);
    rdChk("pin clear", 8'h10, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 8'(5 + i));
      wr(8'h10, 8'h00);
      timer8_pin_model_i.sendPulses(3);
      repeat (6) @(posedge core_clk);
      rdChk("external", 8'h10, (i == 2) ? 8'h06 : 8'h03);
    end
    wr(8'h00, 8'h00);
    wr(8'h08, 8'h09);
    wr(8'h0C, 8'h03);
    wr(8'h04, 8'h16); // direct pwm output
    wr(8'h00, 8'h09); // clear on a
    runLen(1'b1);
    `CHK("pwm width", 6, n)
    runLen(1'b0);
    `CHK("pwm gap", 14, n)
    wr(8'h0C, 8'h05);
    rdChk("buffer b", 8'h0C, 8'h05);
    runLen(1'b1);
    `CHK("new width", 10, n)
    wr(8'h08, 8'h02);
    repeat (600) @(posedge core_clk);
    n = 0;
    repeat (30) begin
      @(posedge core_clk);
      n += (outPin !== 1'b1);
    end
    `CHK("saturated", 0, n)
    wr(8'h04, 8'h0B);
    wr(8'h08, 8'h03);
    wr(8'h0C, 8'h03);
    runLen(1'b1);
    `CHK("toggle first", 8, n)
    @(posedge core_clk);
    clkEn <= 1'b0;
    repeat (5) @(posedge core_clk);
    clkEn <= 1'b1;
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    rdChk("standby status", 8'h04, 8'h00);
    rdChk("standby const", 8'h08, 8'hFF);
    `CHK("standby pin", 1'b0, outPin)
    `CHK("load edges", 1'b1, timer8_pin_model_i.loadRises > 0)
    endOfTest();
  end
endmodule // test_timer8_clock_flags_output
bind timer8_channel timer8_channel_props props_i (
  .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn),
  .standby(standby), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timerOutputPin(timerOutputPin),
  .timerOutputActive(timerOutputActive));
